// ==== port_pin_mux.sv ====
// Shared low result pins: parallel bits or serial port with config inputs.
module port_pin_mux (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [port_mux_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core, on pclk.
  input wire logic [port_mux_pkg::RESULT_W-1:0] result,
  input wire logic conv_busy,
  input wire logic conv_done,
  // Mode select pin.
  input wire logic interface_select,
  // Shared data pins 0 to 7.
  input wire logic [port_mux_pkg::PIN_W-1:0] d_in,
  output logic [port_mux_pkg::PIN_W-1:0] d_out,
  output logic [port_mux_pkg::PIN_W-1:0] d_oe,
  // Serial bit clock pin.
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  // Serial data and frame marker.
  output logic serial_result_output,
  output logic frame_marker
);
  import port_mux_pkg::*;

  logic [CFG_W-1:0] pin_sync;
  logic serial_mode, clk_ext, marker_low, clk_inv, read_chain;
  logic [7:0] div, next_div;
  logic start_req, next_start_req;
  logic [31:0] next_prdata;
  logic [31:0] status_word;
  logic wr_access, rd_setup, mapped;
  logic [PIN_W-1:0] next_d_out, next_d_oe;
  frame_state_t state, next_state;
  logic [7:0] div_cnt, next_div_cnt;
  logic phase, next_phase;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [RESULT_W-1:0] int_word, next_int_word;
  logic int_serial_result_output, next_int_serial_result_output;
  logic next_sclk_out, next_sclk_oe, next_marker;
  logic busy_prev, busy_rise, start_int, int_mode;
  logic req, next_req, ack_seen;
  logic [RESULT_W-1:0] hold_word, next_hold_word;
  logic link_clk, req_link, ack_link, next_ack_link;
  logic [RESULT_W-1:0] shreg, next_shreg;
  logic [4:0] quiet_cnt, next_quiet_cnt;

  // Config pins pass two flops; pins 4 to 7 only mean config in serial mode.
  sync2 #(.W(CFG_W)) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({interface_select, d_in[PIN_W-1:PIN_CLK_SRC]}),
    .q(pin_sync)
  );
  assign serial_mode = pin_sync[4]; // see (R12)
  assign clk_ext = serial_mode & pin_sync[PIN_CLK_SRC-4]; // see (R3)
  assign marker_low = serial_mode & pin_sync[PIN_MARKER_POL-4];
  assign clk_inv = serial_mode & pin_sync[PIN_CLK_INV-4];
  assign read_chain = serial_mode & pin_sync[PIN_READ_CHAIN-4]; // see (R8)
  assign int_mode = serial_mode & ~clk_ext;

  // APB decode; the slave never inserts wait states.
  assign pready = 1'b1;
  assign wr_access = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_DIV) ||
                  (paddr == OFS_STATUS);
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_SERIAL_BIT] = serial_mode;
    status_word[ST_EXT_BIT] = clk_ext;
    status_word[ST_MARKER_BIT] = marker_low;
    status_word[ST_INV_BIT] = clk_inv;
    status_word[ST_READ_BIT] = read_chain;
    status_word[ST_BUSY_BIT] = (state == ST_SHIFT);
  end

  // Register writes and read data; read data is captured in the setup cycle.
  always_comb begin
    next_div = div;
    next_start_req = 1'b0;
    next_prdata = prdata;
    if (wr_access && paddr == OFS_DIV) begin
      next_div = pwdata[7:0];
    end
    if (wr_access && paddr == OFS_CTRL) begin
      next_start_req = pwdata[CTRL_START_BIT];
    end
    if (rd_setup) begin
      unique case (paddr)
        OFS_DIV: next_prdata = {24'h00_0000, div};
        OFS_STATUS: next_prdata = status_word;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= DIV_RESET;
      start_req <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      div <= next_div;
      start_req <= next_start_req;
      prdata <= next_prdata;
    end
  end

  // Shared pins: low nibble always out, high nibble out only in parallel.
  always_comb begin
    next_d_out = result[PIN_W-1:0];
    next_d_oe = OE_PARALLEL; // see (R2)
    if (serial_mode) begin
      next_d_out[PIN_W-1:PIN_CLK_SRC] = 4'h0;
      next_d_oe = OE_SERIAL; // see (R1) (R3) (R12)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_out <= 8'h00;
      d_oe <= OE_RESET;
    end else begin
      d_out <= next_d_out;
      d_oe <= next_d_oe;
    end
  end

  // Read start: at conversion start in read-during mode, else at done.
  assign busy_rise = conv_busy & ~busy_prev;
  assign start_int = int_mode & (state == ST_IDLE) &
    (start_req | (read_chain ? busy_rise : conv_done)); // see (R10) (R11)

  // Internal frame: the clock divides pclk; data changes on falling phase
  // so the host samples a settled bit on each rising phase.
  always_comb begin
    next_state = state;
    next_div_cnt = div_cnt;
    next_phase = phase;
    next_bit_cnt = bit_cnt;
    next_int_word = int_word;
    next_int_serial_result_output = int_serial_result_output;
    unique case (state)
      ST_IDLE: begin
        next_phase = 1'b0;
        if (start_int) begin
          next_state = ST_SHIFT;
          next_div_cnt = 8'h00;
          next_bit_cnt = 5'h00;
          next_int_word = result;
          next_int_serial_result_output = result[RESULT_W-1];
        end
      end
      ST_SHIFT: begin
        if (!int_mode) begin
          next_state = ST_IDLE;
          next_int_serial_result_output = 1'b0;
        end else if (div_cnt == div) begin
          next_div_cnt = 8'h00;
          next_phase = ~phase;
          if (!phase) begin
            next_bit_cnt = bit_cnt + 5'h01;
          end else if (bit_cnt == BITS_PER_WORD) begin
            next_state = ST_IDLE; // see (R14)
            next_int_serial_result_output = 1'b0;
          end else begin
            next_int_word = {int_word[RESULT_W-2:0], 1'b0};
            next_int_serial_result_output = int_word[RESULT_W-2];
          end
        end else begin
          next_div_cnt = div_cnt + 8'h01;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_sclk_out = next_phase ^ clk_inv; // see (R7)
    next_sclk_oe = int_mode; // see (R4) (R5)
    next_marker = int_mode & ((next_state == ST_SHIFT) ^ marker_low);
  end

  // A divide value changed mid-frame applies to the current half period; one below the running count lets it wrap through 255.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      div_cnt <= 8'h00;
      phase <= 1'b0;
      bit_cnt <= 5'h00;
      int_word <= 16'h0000;
      int_serial_result_output <= 1'b0;
      sclk_out <= 1'b0;
      sclk_oe <= 1'b0;
      frame_marker <= 1'b0;
      busy_prev <= 1'b0;
    end else begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      int_word <= next_int_word;
      int_serial_result_output <= next_int_serial_result_output;
      sclk_out <= next_sclk_out; // see (R4)
      sclk_oe <= next_sclk_oe;
      frame_marker <= next_marker; // see (R6) (R14)
      busy_prev <= conv_busy;
    end
  end

  // Word handoff to the link domain: a new result is held only after the
  // previous one was acknowledged, so the link never sees it change.
  sync2 #(.W(1)) u_ack_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(ack_link),
    .q(ack_seen)
  );

  always_comb begin
    next_req = req;
    next_hold_word = hold_word;
    if (conv_done && (req == ack_seen)) begin
      next_hold_word = result;
      next_req = ~req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= 1'b0;
      hold_word <= 16'h0000;
    end else begin
      req <= next_req;
      hold_word <= next_hold_word;
    end
  end

  // Received clock, inverted on request; the polarity pin must stay put
  // during a read or the link sees a spurious edge.
  assign link_clk = sclk_in ^ clk_inv; // see (R7) (R15)

  sync2 #(.W(1)) u_req_sync (
    .clk(link_clk),
    .rst_n(presetn),
    .d(req),
    .q(req_link)
  );

  // A new word loads at the first link edge after it arrives; later edges
  // shift it out MSB first while the chain input fills from the bottom.
  // The quiet count saturates at sixteen edges with no load in between.
  always_comb begin
    next_ack_link = ack_link;
    next_shreg = {shreg[RESULT_W-2:0], d_in[PIN_READ_CHAIN]}; // see (R9)
    next_quiet_cnt = quiet_cnt + {4'h0, quiet_cnt != BITS_PER_WORD};
    if (req_link != ack_link) begin
      next_shreg = hold_word;
      next_quiet_cnt = 5'h00;
      next_ack_link = req_link;
    end
  end

  // Updates on the rising edge of the effective link clock.
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      ack_link <= 1'b0;
      shreg <= 16'h0000;
      quiet_cnt <= 5'h00;
    end else begin
      ack_link <= next_ack_link;
      shreg <= next_shreg; // see (R5) (R13)
      quiet_cnt <= next_quiet_cnt;
    end
  end

  // Serial data source follows the clock source.
  assign serial_result_output = clk_ext ? shreg[RESULT_W-1] : int_serial_result_output;

  // Checks on the pclk side.
  a_low_pins_out: assert property (@(posedge pclk) // see (R1)
    disable iff (!presetn) d_oe[3:0] == 4'hF)
    else $error("Low result pins not driven.");
  a_par_upper_pins: assert property (@(posedge pclk) // see (R2)
    disable iff (!presetn) !serial_mode |=> d_oe[7:4] == 4'hF &&
      d_out[7:4] == $past(result[7:4]))
    else $error("Parallel upper nibble not driven with result.");
  a_ser_upper_in: assert property (@(posedge pclk) // see (R3)
    disable iff (!presetn) serial_mode |=> d_oe[7:4] == 4'h0)
    else $error("Config pins driven in serial mode.");
  a_int_clk_drive: assert property (@(posedge pclk) // see (R4)
    disable iff (!presetn) int_mode |=> sclk_oe)
    else $error("Internal clock not driven out.");
  a_ext_clk_input: assert property (@(posedge pclk) // see (R5)
    disable iff (!presetn) clk_ext |=> !sclk_oe)
    else $error("Clock pin driven with external clock.");
  a_marker_level: assert property (@(posedge pclk) // see (R6)
    disable iff (!presetn) int_mode && $stable(pin_sync) |->
      frame_marker == ((state == ST_SHIFT) ^ marker_low))
    else $error("Frame marker level wrong.");
  a_clk_invert: assert property (@(posedge pclk) // see (R7)
    disable iff (!presetn) state == ST_SHIFT && $stable(pin_sync) |->
      sclk_out == (phase ^ clk_inv))
    else $error("Bit clock polarity wrong.");
  a_frame_length: assert property (@(posedge pclk) // see (R14)
    disable iff (!presetn) state == ST_SHIFT && next_state == ST_IDLE &&
      int_mode |-> bit_cnt == BITS_PER_WORD)
    else $error("Frame ended before sixteen bits.");
  a_read_during: assert property (@(posedge pclk) // see (R10)
    disable iff (!presetn) state == ST_IDLE && int_mode && read_chain &&
      busy_rise |=> state == ST_SHIFT ##1
      int_serial_result_output == $past(result[RESULT_W-1], 2))
    else $error("No read at conversion start.");
  a_read_after: assert property (@(posedge pclk) // see (R11)
    disable iff (!presetn) state == ST_IDLE && int_mode && !read_chain &&
      !start_req && !conv_done |=> state == ST_IDLE)
    else $error("Read started before conversion done.");

  // Check on the link side, once sixteen edges passed with no load.
  a_chain_delay: assert property (@(posedge link_clk) // see (R9)
    disable iff (!presetn) quiet_cnt == BITS_PER_WORD |->
      shreg[RESULT_W-1] == $past(d_in[PIN_READ_CHAIN], 16))
    else $error("Chain input not seen sixteen clocks later.");

  c_int_frame: cover property (@(posedge pclk) disable iff (!presetn)
    state == ST_SHIFT && next_state == ST_IDLE && bit_cnt == LAST_BIT + 5'h01);
  c_parallel: cover property (@(posedge pclk) disable iff (!presetn)
    !serial_mode ##1 serial_mode);
  c_link_load: cover property (@(posedge link_clk) disable iff (!presetn)
    req_link != ack_link);

endmodule

// ==== port_mux_pkg.sv ====
// Constants, register map and state encodings for the result port pin mux.
//
// Operation
// (R1) Result bits 0 to 3 always drive their four low pins as outputs.
// (R2) Parallel mode drives pins 4 to 7 with result bits 4 to 7.
// (R3) Serial mode makes pin 4 an input choosing internal or external clock.
// (R4) Internal clock selected: the device makes the bit clock and drives it.
// (R5) External clock selected: host supplies the clock, output follows it.
// (R6) Frame marker is active high when polarity pin low, else active low.
// (R7) Clock inversion pin high inverts the bit clock, made or received.
// (R8) Pin 7 is chain input or read-mode select, chosen by clock source.
// (R9) External clock: chain input appears on serial output 16 clocks later.
// (R10) Internal clock, read mode high: result shifts out during conversion.
// (R11) Internal clock, read mode low: result shifts out after conversion.
// (R12) Select input low chooses the parallel port, high the serial port.
// (R13) External clock, no inversion: data changes on rising clock edge.
// (R14) Internal clock: marker asserts at read start, holds while data valid.
// (R15) Host keeps select and serial configuration pins steady during reads.
package port_mux_pkg;

  // Widths of the result word, of the shared pin group and of the synchronised config group.
  localparam int RESULT_W = 16;
  localparam int PIN_W = 8;
  localparam int CFG_W = 5;

  // Pin positions of the serial configuration inputs in the shared group.
  localparam int PIN_CLK_SRC = 4;
  localparam int PIN_MARKER_POL = 5;
  localparam int PIN_CLK_INV = 6;
  localparam int PIN_READ_CHAIN = 7;

  // Output enables of the shared pins in each mode.
  localparam logic [7:0] OE_PARALLEL = 8'hFF;
  localparam logic [7:0] OE_SERIAL = 8'h0F;
  localparam logic [7:0] OE_RESET = 8'h0F;

  // APB register map, byte addresses.
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIV = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Control register: bit 0 written as one starts an internal read.
  localparam int CTRL_START_BIT = 0;
  // Half period of the internal bit clock, in pclk cycles minus one.
  localparam logic [7:0] DIV_RESET = 8'h01;

  // Status register field positions.
  localparam int ST_SERIAL_BIT = 0;
  localparam int ST_EXT_BIT = 1;
  localparam int ST_MARKER_BIT = 2;
  localparam int ST_INV_BIT = 3;
  localparam int ST_READ_BIT = 4;
  localparam int ST_BUSY_BIT = 5;

  // Bits in one serial frame.
  localparam logic [4:0] BITS_PER_WORD = 5'h10;
  localparam logic [4:0] LAST_BIT = 5'h0F;

  // Internal read sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } frame_state_t;

endpackage

// ==== sync2.sv ====
// Two flip-flop synchroniser for a group of independent levels.
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset of the receiving domain.
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // The first stage feeds only the second stage, never any logic.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ==== host_model.sv ====
// Host side model: config pins, link clock and serial capture.
module host_model (
  // Pin levels held by the host.
  input wire logic [3:0] cfg,
  output logic [3:0] pin_drive,
  output logic sclk_in,
  // Serial data from the device.
  input wire logic serial_result_output
);
  timeunit 1ns;
  timeprecision 1ns;
  logic raw_clk = 1'b0;
  logic chain_on = 1'b0;
  logic chain_bit = 1'b0;
  logic [47:0] chain_pat = 48'h5A3C_96F0_C3A5;
  logic [47:0] cap = '0;
  // Config stays put between frames; pin 7 carries chain data in a burst.
  assign pin_drive = {chain_on ? chain_bit : cfg[3], cfg[2:0]};
  // The clock stands still outside bursts, so idle shows only inversion.
  assign sclk_in = raw_clk ^ cfg[2];
  // One burst of 48 ns link clocks; data is valid at each falling edge.
  task automatic run_link(input int n);
    chain_on = 1'b1;
    for (int k = 1; k <= n; k++) begin
      chain_bit = chain_pat[k];
      #24 raw_clk = 1'b1;
      #24 raw_clk = 1'b0;
      cap[k] = serial_result_output;
    end
    chain_on = 1'b0;
  endtask
endmodule

// ==== tb_top.sv ====
// Testbench for the result port pin mux with a host model.
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
  n_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import port_mux_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] result = 16'h0000;
  logic conv_busy = 1'b0;
  logic conv_done = 1'b0;
  logic interface_select = 1'b0;
  logic [3:0] cfg = 4'h0;
  logic [3:0] host_pins;
  logic host_sclk;
  logic [7:0] pins;
  logic [7:0] d_out;
  logic [7:0] d_oe;
  logic sclk_out;
  logic sclk_oe;
  logic sclk_wire;
  logic serial_result_output;
  logic frame_marker;
  logic [31:0] rd;
  logic err;
  logic [15:0] got;
  logic [15:0] chn;
  logic [15:0] exc;
  int n_errors = 0;
  int checks = 0;
  // A pin shows the device while it drives, the host otherwise.
  assign pins = (d_oe & d_out) | (~d_oe & {host_pins, 4'h0});
  assign sclk_wire = sclk_oe ? sclk_out : host_sclk;
  always #25 pclk = ~pclk;
  port_pin_mux port_pin_mux_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .result(result),
    .conv_busy(conv_busy), .conv_done(conv_done),
    .interface_select(interface_select), .d_in(pins), .d_out(d_out),
    .d_oe(d_oe), .sclk_in(sclk_wire), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .serial_result_output(serial_result_output),
    .frame_marker(frame_marker)
  );
  host_model host_model_inst (
    .cfg(cfg), .pin_drive(host_pins), .sclk_in(host_sclk),
    .serial_result_output(serial_result_output)
  );
  // One APB transfer; the request holds until pready is seen high, and
  // only the watchdog ends a wait that never gets an answer.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Mode pins change only under reset, so no frame sees them move.
  task automatic do_reset(input logic s, input logic [3:0] c);
    @(posedge pclk);
    interface_select <= s;
    cfg <= c;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    `CHK("oe_reset", OE_RESET, d_oe)
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  // Waits at falling pclk for the marker or the uninverted bit clock.
  task automatic wait_for(input logic mk, input logic lvl);
    int w;
    w = 0;
    do begin
      @(negedge pclk);
      w++;
    end while (((mk ? frame_marker : sclk_out ^ cfg[2]) !== lvl) && w < 300);
    if (w >= 300) `CHK("wait", 1'b0, 1'b1)
  endtask
  // Takes one internal frame; bits are stable while the clock is high.
  task automatic shift_in(input logic [15:0] exp);
    logic [15:0] g;
    wait_for(1'b1, ~cfg[1]);
    for (int b = 15; b >= 0; b--) begin
      wait_for(1'b0, 1'b1);
      g[b] = serial_result_output;
      `CHK("marker_on", ~cfg[1], frame_marker)
      wait_for(1'b0, 1'b0);
    end
    `CHK("serial_word", exp, g)
    repeat (8) @(negedge pclk);
    `CHK("marker_off", cfg[1], frame_marker)
  endtask
  task automatic print_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // The whole run is under a thousand cycles; this bound of 8000 cycles cuts a hang.
  initial begin
    #400000;
    `CHK("watchdog", 1'b0, 1'b1)
    print_verdict();
  end
  initial begin
    do_reset(1'b0, 4'h0);
    result <= 16'hC35A;
    repeat (4) @(posedge pclk);
    `CHK("oe_par", OE_PARALLEL, d_oe)
    `CHK("d_par", 8'h5A, d_out)
    `CHK("sclk_oe_par", 1'b0, sclk_oe)
    result <= 16'h3CA5;
    repeat (4) @(posedge pclk);
    `CHK("d_par2", 8'hA5, d_out)
    $display("test parallel done");
    apb(1'b0, OFS_DIV, 32'h0);
    `CHK("div_reset", DIV_RESET, rd[7:0])
    apb(1'b1, OFS_DIV, 32'h0000_0002);
    apb(1'b0, OFS_DIV, 32'h0);
    `CHK("div_rw", 8'h02, rd[7:0])
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped", 1'b1, err)
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      do_reset(1'b1, {1'b0, m[1:0], 1'b0});
      result <= 16'h9C3B;
      repeat (3) @(posedge pclk);
      `CHK("oe_ser", OE_SERIAL, d_oe)
      `CHK("sclk_oe_int", 1'b1, sclk_oe)
      `CHK("d_low", 4'hB, d_out[3:0])
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("status", {2'b00, m[1:0], 2'b01}, rd[5:0])
      apb(1'b1, OFS_CTRL, 32'h0000_0001);
      shift_in(16'h9C3B);
    end
    $display("test internal clock done");
    do_reset(1'b1, 4'h8);
    result <= 16'h5AA5;
    @(posedge pclk);
    conv_busy <= 1'b1;
    shift_in(16'h5AA5);
    @(posedge pclk);
    conv_busy <= 1'b0;
    do_reset(1'b1, 4'h0);
    conv_busy <= 1'b1;
    repeat (20) @(posedge pclk);
    `CHK("no_early", 1'b0, frame_marker)
    result <= 16'h1234;
    conv_busy <= 1'b0;
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
    shift_in(16'h1234);
    $display("test read modes done");
    for (int v = 0; v < 2; v++) begin
      do_reset(1'b1, {1'b0, v[0], 2'b01});
      `CHK("sclk_oe_ext", 1'b0, sclk_oe)
      result <= 16'hE71D;
      conv_done <= 1'b1;
      @(posedge pclk);
      conv_done <= 1'b0;
      repeat (4) @(posedge pclk);
      host_model_inst.run_link(34);
      // The load edge takes no chain bit, so chain data starts one later.
      for (int i = 0; i < 16; i++) begin
        got[15 - i] = host_model_inst.cap[3 + i];
        chn[15 - i] = host_model_inst.cap[19 + i];
        exc[15 - i] = host_model_inst.chain_pat[4 + i];
      end
      `CHK("ext_word", 16'hE71D, got)
      `CHK("chain", exc, chn)
      `CHK("marker_ext", 1'b0, frame_marker)
    end
    $display("test external clock done");
    print_verdict();
  end
endmodule
